/* File: uip_pkg.sv */
// Shared constants and carrier types of the serial interrupt priority block.
package uip_pkg;

	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_IE = 8'h01;
	localparam logic [7:0] IDX_ID = 8'h02;
	localparam logic [7:0] IDX_EVT_STATUS = 8'h08;
	localparam logic [7:0] IDX_EVT_MASK = 8'h09;
	localparam logic [9:0] ADDR_IE = {IDX_IE, 2'b00};
	localparam logic [9:0] ADDR_ID = {IDX_ID, 2'b00};
	localparam logic [9:0] ADDR_EVT_STATUS = {IDX_EVT_STATUS, 2'b00};
	localparam logic [9:0] ADDR_EVT_MASK = {IDX_EVT_MASK, 2'b00};

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int IE_RDA = 0;
	localparam int IE_TRANSMIT_HOLDING_EMPTY = 1;
	localparam int IE_LS = 2;
	localparam int IE_MS = 3;
	localparam int EVT_TIMEOUT = 4;
	localparam int LCR_DIV_BIT = 7;
	localparam int FCR_EN_BIT = 0;
	localparam int FCR_TRIG_LO = 6;
	localparam logic [3:0] IE_RESET = 4'h0;
	localparam logic [4:0] EVT_RESET = 5'h00;
	localparam logic [7:0] ID_RESET = 8'h01;

	// ----------------------------------------------------------------
	// Identification codes and counts
	// ----------------------------------------------------------------
	localparam logic [1:0] ID_LS = 2'b11;
	localparam logic [1:0] ID_RDA = 2'b10;
	localparam logic [1:0] ID_TRANSMIT_HOLDING_EMPTY = 2'b01;
	localparam logic [1:0] ID_MS = 2'b00;
	localparam logic [2:0] CHAR_TIMEOUT = 3'h4;
	localparam logic [4:0] TRIG_1 = 5'h01;
	localparam logic [4:0] TRIG_4 = 5'h04;
	localparam logic [4:0] TRIG_8 = 5'h08;
	localparam logic [4:0] TRIG_14 = 5'h0e;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic overrun;
		logic parity_error;
		logic framing_error;
		logic break_indication;
	} uip_line_err_t;

	typedef struct packed {
		logic receive_buffer_read;
		logic line_status_reg_read;
		logic modem_status_reg_read;
		logic transmit_holding_write;
	} uip_host_strobe_t;

endpackage : uip_pkg

/* File: uip_top.sv */
// Interrupt enable, priority and identification logic of one serial channel.
//
// How it works
// RULE_01 - Enable register at index 1 only when divisor bit clear.
// RULE_02 - Modem status change raises modem interrupt when enabled.
// RULE_03 - Line errors raise line status interrupt when enabled.
// RULE_04 - Holding register empty raises transmit interrupt when enabled.
// RULE_05 - Enable bit 0 gates data and time-out.
// RULE_06 - Fixed priority: line, data/time-out, transmit, modem.
// RULE_07 - Identification frozen during its own read access.
// RULE_08 - Identification bit 0 low while any enabled source pending.
// RULE_09 - Bits 2:1 encode highest source: 11,10,01,00.
// RULE_10 - Bit 3 marks time-out, only in FIFO mode.
// RULE_11 - Time-out after 4 idle character times, non-empty.
// RULE_12 - Data interrupt clears on buffer read or below trigger; code drops it only when rx_data_ready or the fill falls.
// RULE_13 - Transmit interrupt clears on identification read or write.
// RULE_14 - Line, modem, time-out clear on their own reads.
// RULE_15 - Bits 7:6 follow the FIFO enable bit.
// RULE_16 - Bits 5:4 always read zero.
// RULE_17 - Divisor access select is line control bit 7.
// RULE_18 - FIFO mode is FIFO control bit 0.
// RULE_19 - Interrupt output high while any enabled source pending.
module uip_top #(
	parameter int COUNT_W = 5
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] line_control,
	input wire logic [7:0] fifo_control,
	input wire uip_pkg::uip_line_err_t line_err,
	input wire logic modem_status_change,
	input wire logic transmit_holding_empty,
	input wire logic rx_data_ready,
	input wire logic [COUNT_W-1:0] rx_count,
	input wire logic rx_push,
	input wire logic char_tick,
	input wire uip_pkg::uip_host_strobe_t host_strobe,
	output logic [7:0] interrupt_identification,
	output logic intr
);
	import uip_pkg::*;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [3:0] interrupt_enable;
	logic [4:0] evt_status;
	logic [4:0] evt_mask;
	logic [9:0] wr_addr;
	logic wr_pend;
	logic id_busy_q;
	logic [31:0] read_mux;
	wire addr_ok = hsel && htrans[1] && hready;
	wire rd_req = addr_ok && !hwrite;
	wire divisor_access_select = line_control[LCR_DIV_BIT]; // RULE_17
	wire fifo_mode = fifo_control[FCR_EN_BIT]; // RULE_18
	wire [9:0] a_addr = haddr[9:0];
	wire ie_hit_rd = rd_req && a_addr == ADDR_IE && !divisor_access_select; // RULE_01
	wire id_rd = rd_req && a_addr == ADDR_ID;
	wire evt_rd = rd_req && a_addr == ADDR_EVT_STATUS;
	wire ie_wr = wr_pend && wr_addr == ADDR_IE && !divisor_access_select; // RULE_01
	wire mask_wr = wr_pend && wr_addr == ADDR_EVT_MASK;
	wire id_busy = id_rd || id_busy_q;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb begin
		read_mux = 32'h0000_0000;
		if (ie_hit_rd) begin
			read_mux = {28'h0000000, interrupt_enable}; // RULE_01
		end else if (id_rd) begin
			read_mux = {24'h000000, interrupt_identification};
		end else if (evt_rd) begin
			read_mux = {27'h0000000, evt_status};
		end else if (rd_req && a_addr == ADDR_EVT_MASK) begin
			read_mux = {27'h0000000, evt_mask};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 10'h000;
			id_busy_q <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend <= addr_ok && hwrite;
			wr_addr <= a_addr;
			id_busy_q <= id_rd;
			hrdata <= rd_req ? read_mux : hrdata;
		end
	end

	// ----------------------------------------------------------------
	// Enable and mask registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_enable <= IE_RESET;
			evt_mask <= EVT_RESET;
		end else begin
			if (ie_wr) begin
				interrupt_enable <= hwdata[3:0]; // RULE_01
			end
			if (mask_wr) begin
				evt_mask <= hwdata[4:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt sources
	// ----------------------------------------------------------------
	function automatic logic [COUNT_W-1:0] trig_level(input logic [1:0] sel);
		logic [4:0] lvl;
		case (sel)
			2'b00: lvl = TRIG_1;
			2'b01: lvl = TRIG_4;
			2'b10: lvl = TRIG_8;
			default: lvl = TRIG_14;
		endcase
		return COUNT_W'(lvl);
	endfunction : trig_level

	logic ls_pend;
	logic ms_pend;
	logic transmit_holding_empty_pend;
	logic transmit_holding_empty_q;
	logic ie_transmit_holding_empty_q;
	logic [2:0] idle_chars;
	wire rx_pop = host_strobe.receive_buffer_read;
	wire rx_nonempty = rx_count != '0;
	wire [COUNT_W-1:0] trig = trig_level(fifo_control[FCR_TRIG_LO +: 2]);
	wire any_err = |line_err;
	wire ls_set = any_err; // RULE_03
	wire ms_set = modem_status_change; // RULE_02
	wire transmit_holding_empty_rise = transmit_holding_empty && !transmit_holding_empty_q;
	wire transmit_holding_empty_arm = interrupt_enable[IE_TRANSMIT_HOLDING_EMPTY] && !ie_transmit_holding_empty_q;
	wire transmit_holding_empty_set = transmit_holding_empty_rise || (transmit_holding_empty_arm && transmit_holding_empty); // RULE_04
	wire id_is_transmit_holding_empty = interrupt_identification[3:0] == {1'b0, ID_TRANSMIT_HOLDING_EMPTY, 1'b0};
	wire transmit_holding_empty_clr = host_strobe.transmit_holding_write || (id_rd && id_is_transmit_holding_empty); // RULE_13
	// Data interrupt is a level: it follows rx_data_ready, or in FIFO mode
	// the fill against the trigger; a buffer read does not enter it.
	wire rda_pend = fifo_mode ? rx_count >= trig : rx_data_ready; // RULE_12
	wire to_pend = fifo_mode && rx_nonempty && idle_chars == CHAR_TIMEOUT; // RULE_11

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ls_pend <= 1'b0;
			ms_pend <= 1'b0;
			transmit_holding_empty_pend <= 1'b0;
			transmit_holding_empty_q <= 1'b0;
			ie_transmit_holding_empty_q <= 1'b0;
		end else begin
			ls_pend <= ls_set || (ls_pend && !host_strobe.line_status_reg_read); // RULE_14
			ms_pend <= ms_set || (ms_pend && !host_strobe.modem_status_reg_read); // RULE_14
			transmit_holding_empty_pend <= transmit_holding_empty && (transmit_holding_empty_set || (transmit_holding_empty_pend && !transmit_holding_empty_clr)); // RULE_13
			transmit_holding_empty_q <= transmit_holding_empty;
			ie_transmit_holding_empty_q <= interrupt_enable[IE_TRANSMIT_HOLDING_EMPTY];
		end
	end

	// Idle character counter, restarted by any push or pop (RULE_14 on pop).
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_chars <= 3'h0;
		end else if (!fifo_mode || !rx_nonempty || rx_push || rx_pop) begin
			idle_chars <= 3'h0; // RULE_11
		end else if (char_tick && idle_chars != CHAR_TIMEOUT) begin
			idle_chars <= idle_chars + 3'h1; // RULE_11
		end
	end

	// ----------------------------------------------------------------
	// Priority and identification
	// ----------------------------------------------------------------
	wire en_ls = ls_pend && interrupt_enable[IE_LS]; // RULE_03
	wire en_rda = rda_pend && interrupt_enable[IE_RDA]; // RULE_05
	wire en_to = to_pend && interrupt_enable[IE_RDA]; // RULE_05
	wire en_transmit_holding_empty = transmit_holding_empty_pend && interrupt_enable[IE_TRANSMIT_HOLDING_EMPTY]; // RULE_04
	wire en_ms = ms_pend && interrupt_enable[IE_MS]; // RULE_02
	wire any_en = en_ls || en_rda || en_to || en_transmit_holding_empty || en_ms;
	logic [2:0] id_src;

	always_comb begin
		id_src = {1'b0, ID_MS}; // RULE_06
		if (en_ls) begin
			id_src = {1'b0, ID_LS}; // RULE_09
		end else if (en_to) begin
			id_src = {1'b1, ID_RDA}; // RULE_10
		end else if (en_rda) begin
			id_src = {1'b0, ID_RDA}; // RULE_09
		end else if (en_transmit_holding_empty) begin
			id_src = {1'b0, ID_TRANSMIT_HOLDING_EMPTY}; // RULE_09
		end
	end

	wire [1:0] fifo_bits = fifo_mode ? 2'b11 : 2'b00; // RULE_15
	wire [7:0] id_live = {fifo_bits, 2'b00, id_src, !any_en}; // RULE_16 RULE_08

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_identification <= ID_RESET;
		end else if (!id_busy) begin
			interrupt_identification <= id_live; // RULE_07
		end
	end

	// ----------------------------------------------------------------
	// Event status, mask and interrupt output
	// ----------------------------------------------------------------
	logic [4:0] src_q;
	wire [4:0] src_now = {to_pend, ms_pend, ls_pend, transmit_holding_empty_pend, rda_pend};
	wire [4:0] src_rise = src_now & ~src_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= EVT_RESET;
			evt_status <= EVT_RESET;
		end else begin
			src_q <= src_now;
			evt_status <= src_rise | (evt_rd ? EVT_RESET : evt_status);
		end
	end

	assign intr = any_en || |(evt_status & evt_mask); // RULE_19

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	ie_div_block_a: assert property ( // RULE_01
		wr_pend && wr_addr == ADDR_IE && divisor_access_select
		|=> $stable(interrupt_enable))
		else $error("Enable register written while divisor access set.");
	ms_raise_a: assert property ( // RULE_02
		modem_status_change && interrupt_enable[IE_MS]
		&& $stable(interrupt_enable) |=> ms_pend && en_ms)
		else $error("Modem change did not raise modem interrupt.");
	ls_raise_a: assert property ( // RULE_03
		any_err |=> ls_pend)
		else $error("Line error did not raise line interrupt.");
	transmit_holding_empty_clear_a: assert property ( // RULE_13
		host_strobe.transmit_holding_write && !transmit_holding_empty_set |=> !transmit_holding_empty_pend)
		else $error("Holding write did not clear transmit interrupt.");
	id_freeze_a: assert property ( // RULE_07
		id_rd |=> $stable(interrupt_identification) ##1
		$stable(interrupt_identification))
		else $error("Identification changed during its read.");
	id_pending_a: assert property ( // RULE_08
		!id_busy && !id_busy_q ##1 !id_busy
		|-> interrupt_identification[0] == !$past(any_en))
		else $error("Pending flag disagrees with enabled sources.");
	prio_line_a: assert property ( // RULE_06
		en_ls |-> id_live[3:1] == {1'b0, ID_LS})
		else $error("Line status not reported first.");
	upper_bits_a: assert property ( // RULE_15
		id_live[7:4] == {fifo_mode, fifo_mode, 2'b00})
		else $error("Upper identification bits wrong.");
	timeout_ok_a: assert property ( // RULE_11
		to_pend |-> fifo_mode && rx_nonempty && $past(idle_chars) >= 3'h3)
		else $error("Time-out without idle non-empty FIFO.");
	irq_level_a: assert property ( // RULE_19
		any_en |-> intr)
		else $error("Interrupt output low with enabled source pending.");

	// ----------------------------------------------------------------
	// Code, clear and gating checks
	// ----------------------------------------------------------------
	rda_code_a: assert property ( // RULE_09
		en_rda && !en_ls && !en_to |-> id_live[3:1] == {1'b0, ID_RDA})
		else $error("Data interrupt code wrong.");
	transmit_holding_empty_code_a: assert property ( // RULE_06
		en_transmit_holding_empty && !en_ls && !en_rda && !en_to
		|-> id_live[3:1] == {1'b0, ID_TRANSMIT_HOLDING_EMPTY})
		else $error("Transmit interrupt code wrong.");
	ms_code_a: assert property ( // RULE_09
		en_ms && !en_ls && !en_rda && !en_to && !en_transmit_holding_empty
		|-> id_live[3:1] == {1'b0, ID_MS})
		else $error("Modem interrupt code wrong.");
	bit3_plain_a: assert property ( // RULE_10
		!fifo_mode |-> !id_live[3])
		else $error("Time-out bit set outside FIFO mode.");
	bit3_pair_a: assert property ( // RULE_10
		id_live[3] |-> id_live[2])
		else $error("Time-out bit set without bit 2.");
	zero_bits_a: assert property ( // RULE_16
		id_live[5:4] == 2'b00)
		else $error("Identification bits 5:4 not zero.");
	idle_flag_a: assert property ( // RULE_08
		!any_en |-> id_live[3:0] == 4'h1)
		else $error("Idle identification code wrong.");
	ie_read_block_a: assert property ( // RULE_01
		rd_req && a_addr == ADDR_IE && divisor_access_select
		|=> hrdata == 32'h0000_0000)
		else $error("Enable register read while divisor access set.");

	transmit_holding_empty_raise_a: assert property ( // RULE_04
		transmit_holding_empty_rise |=> transmit_holding_empty_pend)
		else $error("Holding empty did not raise transmit interrupt.");
	transmit_holding_empty_id_clear_a: assert property ( // RULE_13
		id_rd && id_is_transmit_holding_empty && !transmit_holding_empty_set |=> !transmit_holding_empty_pend)
		else $error("Identification read did not clear transmit interrupt.");
	ls_clear_a: assert property ( // RULE_14
		host_strobe.line_status_reg_read && !ls_set |=> !ls_pend)
		else $error("Line status read did not clear line interrupt.");
	ms_clear_a: assert property ( // RULE_14
		host_strobe.modem_status_reg_read && !ms_set |=> !ms_pend)
		else $error("Modem status read did not clear modem interrupt.");
	to_pop_clear_a: assert property ( // RULE_14
		rx_pop |=> !to_pend)
		else $error("Buffer read did not clear time-out.");
	rda_drop_a: assert property ( // RULE_12
		fifo_mode && rx_count < trig |-> !rda_pend)
		else $error("Data interrupt pending below trigger level.");

	rda_gate_a: assert property ( // RULE_05
		!interrupt_enable[IE_RDA] |-> !en_rda && !en_to)
		else $error("Data or time-out passed a cleared enable.");
	idle_bound_a: assert property ( // RULE_11
		idle_chars <= CHAR_TIMEOUT)
		else $error("Idle character count beyond time-out.");
	idle_plain_a: assert property ( // RULE_11
		!fifo_mode |=> idle_chars == 3'h0)
		else $error("Idle count runs outside FIFO mode.");
	id_hold_a: assert property ( // RULE_07
		id_busy |=> $stable(interrupt_identification))
		else $error("Identification moved during its access.");
	irq_quiet_a: assert property ( // RULE_19
		!any_en && (evt_status & evt_mask) == EVT_RESET |-> !intr)
		else $error("Interrupt output high with nothing pending.");
	evt_sticky_a: assert property (
		src_rise != EVT_RESET
		|=> (evt_status & $past(src_rise)) == $past(src_rise))
		else $error("Event status lost a new rising source.");

	timeout_seen_c: cover property (en_to ##1 interrupt_identification[3]);
	transmit_holding_empty_by_id_c: cover property (id_rd && id_is_transmit_holding_empty ##1 !transmit_holding_empty_pend);
	ls_over_rda_c: cover property (en_ls && en_rda);
	evt_irq_c: cover property (!any_en && intr);

endmodule : uip_top

/* File: uip_host.sv */
// Host model that issues single word AHB-Lite transfers.
module uip_host (
	input wire logic core_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	event rd_ev;
	logic [31:0] rd_q;
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// Holds each phase until hready is sampled high at a rising edge.
	task automatic xfer(input logic [31:0] a, input logic w,
		input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd_q = hrdata;
		if (!w) begin
			-> rd_ev;
		end
	endtask : xfer
endmodule : uip_host

/* File: tb_top.sv */
// Self-checking bench of the serial interrupt priority block.
module tb_top;
	import uip_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, intr;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] line_control = 8'h00;
	logic [7:0] fifo_control = 8'h00;
	logic [7:0] interrupt_identification;
	uip_line_err_t line_err = '0;
	uip_host_strobe_t host_strobe = '0;
	logic modem_status_change = 1'b0;
	logic transmit_holding_empty = 1'b0;
	logic rx_data_ready = 1'b0;
	logic [4:0] rx_count = 5'h00;
	logic rx_push = 1'b0;
	logic char_tick = 1'b0;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	logic [31:0] exp_q [$];

	uip_top i_dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.line_control, .fifo_control, .line_err, .modem_status_change,
		.transmit_holding_empty, .rx_data_ready, .rx_count, .rx_push,
		.char_tick, .host_strobe, .interrupt_identification, .intr);
	uip_host i_host (.core_clk, .hready(hreadyout), .hrdata, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata);

	initial forever #25 core_clk = ~core_clk;

	task automatic final_report;
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		i_host.xfer({22'h0, a}, 1'b0, 32'h0);
	endtask : rd

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		i_host.xfer({22'h0, a}, 1'b1, d);
	endtask : wr

	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
	endtask : w

	task automatic pulse(input logic [3:0] e, input logic [3:0] s,
		input logic m, input logic k);
		@(posedge core_clk);
		line_err <= uip_line_err_t'(e);
		host_strobe <= uip_host_strobe_t'(s);
		modem_status_change <= m;
		char_tick <= k;
		@(posedge core_clk);
		line_err <= '0;
		host_strobe <= '0;
		modem_status_change <= 1'b0;
		char_tick <= 1'b0;
		w(3);
	endtask : pulse

	// Each finished read is compared with the oldest expected value.
	initial forever begin
		@(i_host.rd_ev);
		chk("hrdata", exp_q.pop_front(), i_host.rd_q);
		chk("hresp", 32'h0, {31'h0, hresp});
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			final_report;
		end
	end

	initial begin
		logic [31:0] r;
		void'($urandom(87720));
		r = $urandom;
		w(5);
		rst_n <= 1'b1;
		rd(ADDR_ID, 32'h01);
		chk("intr", 32'h0, {31'h0, intr});
		wr(ADDR_IE, r);
		rd(ADDR_IE, {28'h0, r[3:0]});
		line_control <= 8'h80;
		wr(ADDR_IE, 32'h0f);
		rd(ADDR_IE, 32'h0);
		line_control <= 8'h00;
		rd(ADDR_IE, {28'h0, r[3:0]});
		wr(ADDR_IE, 32'h0f);
		rd({4'hf, r[5:2], 2'b00}, 32'h0);
		transmit_holding_empty <= 1'b1;
		pulse(4'h1 << r[1:0], 4'h0, 1'b1, 1'b0);
		rd(ADDR_ID, 32'h06);
		chk("intr", 32'h1, {31'h0, intr});
		pulse(4'h0, 4'h4, 1'b0, 1'b0);
		rx_data_ready <= 1'b1;
		w(3);
		rd(ADDR_ID, 32'h04);
		rx_data_ready <= 1'b0;
		w(3);
		rd(ADDR_ID, 32'h02);
		w(3);
		rd(ADDR_ID, 32'h00);
		pulse(4'h0, 4'h2, 1'b0, 1'b0);
		rd(ADDR_ID, 32'h01);
		chk("intr", 32'h0, {31'h0, intr});
		wr(ADDR_IE, 32'h0d);
		wr(ADDR_IE, 32'h0f);
		w(3);
		chk("intr", 32'h1, {31'h0, intr});
		pulse(4'h0, 4'h1, 1'b0, 1'b0);
		chk("intr", 32'h0, {31'h0, intr});
		rd(ADDR_ID, 32'h01);
		transmit_holding_empty <= 1'b0;
		fifo_control <= 8'h01;
		rx_count <= 5'h01;
		w(3);
		rd(ADDR_ID, 32'hc4);
		fifo_control <= 8'h41;
		w(3);
		rd(ADDR_ID, 32'hc1);
		repeat (3) pulse(4'h0, 4'h0, 1'b0, 1'b1);
		rd(ADDR_ID, 32'hc1);
		pulse(4'h0, 4'h0, 1'b0, 1'b1);
		rd(ADDR_ID, 32'hcc);
		pulse(4'h0, 4'h8, 1'b0, 1'b0);
		rd(ADDR_ID, 32'hc1);
		rst_n <= 1'b0;
		fifo_control <= 8'h00;
		rx_count <= 5'h00;
		w(2);
		rst_n <= 1'b1;
		pulse(4'h0, 4'h0, 1'b1, 1'b0);
		chk("intr", 32'h0, {31'h0, intr});
		wr(ADDR_EVT_MASK, 32'h04);
		pulse(4'h2, 4'h0, 1'b0, 1'b0);
		chk("intr", 32'h1, {31'h0, intr});
		rd(ADDR_EVT_STATUS, 32'h0c);
		w(2);
		chk("intr", 32'h0, {31'h0, intr});
		final_report;
	end
endmodule : tb_top
